// >>> src/uart_channel.v
// Behaviour
// (RQ1) Seven interrupt sources per channel
// (RQ2) Line status from overrun, parity, framing, break
// (RQ3) Channel zero: 64-byte transmit and receive FIFOs
// (RQ4) Channels one, two: 16-byte FIFOs
// (RQ5) Status readable anytime, four receive errors
// (RQ6) No divider X: clock over 16*(divisor+2)
// (RQ7) Divider X: clock over (X+1)*(divisor+2)
// (RQ8) Divide-by-one: clock over (divisor+2)
// (RQ9) Flow control only on channels zero, one
// (RQ10) Auto flow: receive only while request asserted
// (RQ11) Deassert request when count reaches trigger
// (RQ12) Auto flow: transmit only while clear asserted
// (RQ13) Function bit 1 selects infrared coding
// (RQ14) Infrared frame: start, eight data, stop
// (RQ15) Infrared rates up to 115.2 kbit/s
// (RQ16) Infrared is half duplex
// (RQ17) Software keeps 10 ms infrared turnaround
// (RQ18) Function LIN bit selects LIN mode
// (RQ19) LIN character: start, eight data, stop
// (RQ20) Otherwise five to eight data bits
// (RQ21) Even, odd or no parity
// (RQ22) One, one and half, two stop bits
// (RQ23) False start bits are discarded
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_channel #(
  parameter CHANNEL = 0
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // Avalon-MM slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Serial pins
  input  wire        rxd,
  output reg         txd,
  input  wire        cts_n,
  output reg         rts_n
);
  localparam AW = (CHANNEL == 0) ? 6 : 4;
  localparam [6:0] DEPTH = (CHANNEL == 0) ? 7'h40 : 7'h10; // RQ3 RQ4
  localparam FLOW = (CHANNEL < 2) ? 1'b1 : 1'b0; // RQ9
  localparam S_IDLE = 3'd0, S_START = 3'd1, S_DATA = 3'd2,
             S_PAR = 3'd3, S_STOP = 3'd4, S_BRK = 3'd5;

  reg  [4:0]  line_reg;
  reg  [7:0]  fifo_reg;
  reg  [31:0] baud_reg;
  reg  [1:0]  func_reg;
  reg  [1:0]  modem_reg;
  reg  [7:0]  rx_mem [0:DEPTH-1];
  reg  [7:0]  tx_mem [0:DEPTH-1];
  reg  [6:0]  rx_wp, rx_rp, tx_wp, tx_rp;
  reg         oe_reg, pe_reg, fe_reg, bi_reg, buf_reg, lin_reg, dcts_reg;
  reg         tout_reg;
  reg         rxd_s1, rxd_s2, cts_s1, cts_s2, cts_d;
  reg  [2:0]  tx_st, rx_st;
  reg  [21:0] tx_cnt, rx_cnt, irda_cnt, tout_cnt;
  reg  [5:0]  tout_bits;
  reg  [2:0]  tx_idx, rx_idx;
  reg  [7:0]  tx_sh, rx_sh;
  reg         tx_half, rx_par;

  wire        acc_w = write & ~waitrequest;
  wire        acc_r = read & ~waitrequest;
  wire        wr_data = acc_w && address == `OFF_DATA;
  wire        rd_data = acc_r && address == `OFF_DATA;
  wire        fixed8 = func_reg[`FUN_LIN] | func_reg[`FUN_IRDA]; // RQ14 RQ19
  wire [2:0]  last_bit = fixed8 ? 3'd7 : {1'b1, line_reg[1:0]}; // RQ20
  wire        par_en = line_reg[3] & ~fixed8; // RQ21
  wire        stop2 = line_reg[2] & ~fixed8;
  wire [6:0]  rx_cnt_f = rx_wp - rx_rp;
  wire [6:0]  tx_cnt_f = tx_wp - tx_rp;
  wire        rx_empty = rx_cnt_f == 7'h00;
  wire        rx_full = rx_cnt_f == DEPTH;
  wire        tx_empty = tx_cnt_f == 7'h00;
  wire        tx_full = tx_cnt_f == DEPTH;

  // Bit period in clk_sys cycles, clk_sys being the baud source.
  wire [21:0] div2 = {6'h00, baud_reg[15:0]} + `BAUD_OFFSET;
  wire [4:0]  xp1 = {1'b0, baud_reg[`BAUD_X_HI:`BAUD_X_LO]} + 5'h01;
  wire [4:0]  mult = !baud_reg[`BAUD_X_EN] ? `OVERSAMPLE : // RQ6
                     baud_reg[`BAUD_X_ONE] ? 5'h01 : xp1; // RQ7 RQ8
  wire [26:0] prod = {5'h00, div2} * {22'h00_0000, mult};
  wire [21:0] bit_len = prod[21:0];
  wire [21:0] half_len = {1'b0, bit_len[21:1]};
  wire [25:0] p3 = {4'h0, bit_len} * 26'h000_0003;
  wire [21:0] pulse_len = p3[25:4];
  wire [21:0] stretch_len = half_len + {2'b00, bit_len[21:2]};

  // Receive line: infrared pulses are stretched into low bits.
  wire        irda = func_reg[`FUN_IRDA]; // RQ13
  wire        tx_busy = tx_st != S_IDLE;
  wire        ir_low = rxd_s2 | (irda_cnt != 22'h00_0000);
  wire        rx_line = !irda ? rxd_s2 :
                        tx_busy ? 1'b1 : ~ir_low; // RQ16
  wire        auto_rts = FLOW & modem_reg[0];
  wire        auto_cts = FLOW & modem_reg[1];
  wire        rx_allow = ~auto_rts | ~rts_n; // RQ10
  wire        cts_ok = ~auto_cts | ~cts_s2; // RQ12
  wire        tx_go = tx_st == S_IDLE && !tx_empty && cts_ok &&
                      !(irda && rx_st != S_IDLE); // RQ16
  wire        rx_push = rx_st == S_STOP && rx_cnt == 22'h00_0000;
  wire [7:0]  rx_byte = rx_sh >> (3'd7 - last_bit);
  wire        rx_brk = rx_push && rx_byte == 8'h00 && !rx_line &&
                       !(par_en && rx_par);

  wire        thre_irq = tx_empty;
  wire        rda_irq = !rx_empty &&
                        rx_cnt_f >= {3'b000, fifo_reg[3:0]};
  wire        rls_irq = oe_reg | pe_reg | fe_reg | bi_reg; // RQ2
  wire [6:0]  irq_src = {lin_reg, buf_reg, dcts_reg, tout_reg,
                         rls_irq, rda_irq, thre_irq}; // RQ1
  wire [31:0] status = {1'b0, tx_cnt_f, 1'b0, rx_cnt_f, 3'b000,
                        cts_s2, tx_busy, tout_reg, dcts_reg, lin_reg,
                        buf_reg, bi_reg, fe_reg, pe_reg, oe_reg,
                        tx_empty, tx_full, rx_empty}; // RQ5

  // Bus slave: one wait state, then the answer.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        case (address)
          `OFF_DATA:   readdata <= {24'h00_0000, rx_mem[rx_rp[AW-1:0]]};
          `OFF_LINE:   readdata <= {27'h000_0000, line_reg};
          `OFF_FIFO:   readdata <= {12'h000, fifo_reg[7:4], 8'h00,
                                    fifo_reg[3:0], 4'h0};
          `OFF_STATUS: readdata <= status;
          `OFF_IRQ:    readdata <= {25'h000_0000, irq_src};
          `OFF_BAUD:   readdata <= baud_reg;
          `OFF_FUNC:   readdata <= {30'h0000_0000, func_reg};
          `OFF_MODEM:  readdata <= {30'h0000_0000, modem_reg};
          default:     readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers, FIFO pointers and sticky flags.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      line_reg <= `RST_LINE;
      fifo_reg <= `RST_FIFO;
      baud_reg <= `RST_BAUD;
      func_reg <= 2'b00;
      modem_reg <= 2'b00;
      rx_wp <= 7'h00;
      rx_rp <= 7'h00;
      tx_wp <= 7'h00;
      tx_rp <= 7'h00;
      {oe_reg, pe_reg, fe_reg, bi_reg} <= 4'h0;
      {buf_reg, lin_reg, dcts_reg} <= 3'b000;
    end else begin
      if (acc_w && address == `OFF_LINE)
        line_reg <= writedata[4:0];
      if (acc_w && address == `OFF_FIFO)
        fifo_reg <= {writedata[`FCR_RTS_HI:`FCR_RTS_LO],
                     writedata[`FCR_RXTRG_HI:`FCR_RXTRG_LO]};
      if (acc_w && address == `OFF_BAUD)
        baud_reg <= writedata;
      if (acc_w && address == `OFF_FUNC)
        func_reg <= writedata[1:0]; // RQ13 RQ18
      if (acc_w && address == `OFF_MODEM)
        modem_reg <= writedata[1:0];
      if (acc_w && address == `OFF_STATUS) begin
        oe_reg <= oe_reg & ~writedata[3];
        pe_reg <= pe_reg & ~writedata[4];
        fe_reg <= fe_reg & ~writedata[5];
        bi_reg <= bi_reg & ~writedata[6];
        buf_reg <= buf_reg & ~writedata[7];
        lin_reg <= lin_reg & ~writedata[8];
        dcts_reg <= dcts_reg & ~writedata[9];
      end
      if (wr_data) begin
        if (tx_full)
          buf_reg <= 1'b1;
        else begin
          tx_mem[tx_wp[AW-1:0]] <= writedata[7:0];
          tx_wp <= tx_wp + 7'h01;
        end
      end
      if (tx_go)
        tx_rp <= tx_rp + 7'h01;
      if (rd_data && !rx_empty)
        rx_rp <= rx_rp + 7'h01;
      if (rx_push) begin
        if (rx_full) begin
          oe_reg <= 1'b1; // RQ2
          buf_reg <= 1'b1;
        end else begin
          rx_mem[rx_wp[AW-1:0]] <= rx_byte;
          rx_wp <= rx_wp + 7'h01;
        end
        if (par_en && (^rx_byte ^ rx_par ^ ~line_reg[4]))
          pe_reg <= 1'b1; // RQ21
        if (!rx_line)
          fe_reg <= 1'b1;
        if (rx_brk)
          bi_reg <= 1'b1;
        if (rx_brk && func_reg[`FUN_LIN])
          lin_reg <= 1'b1; // RQ1
      end
      if (FLOW && cts_s2 != cts_d)
        dcts_reg <= 1'b1;
      if (acc_w && address == `OFF_FIFO && writedata[`FCR_RX_RST])
        rx_rp <= rx_wp;
      if (acc_w && address == `OFF_FIFO && writedata[`FCR_TX_RST])
        tx_rp <= tx_wp;
    end
  end

  // Pin synchronisers and request-to-send.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {rxd_s1, rxd_s2, cts_s1, cts_s2, cts_d} <= 5'h1F;
      rts_n <= 1'b1;
      irda_cnt <= 22'h00_0000;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      cts_d <= cts_s2;
      if (!FLOW)
        rts_n <= 1'b1;
      else if (auto_rts)
        rts_n <= rx_cnt_f >= {3'b000, fifo_reg[7:4]}; // RQ11
      else
        rts_n <= 1'b0;
      if (irda && rxd_s2)
        irda_cnt <= stretch_len;
      else if (irda_cnt != 22'h00_0000)
        irda_cnt <= irda_cnt - 22'h00_0001;
    end
  end

  // Transmitter.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_st <= S_IDLE;
      tx_cnt <= 22'h00_0000;
      tx_idx <= 3'd0;
      tx_sh <= 8'h00;
      tx_half <= 1'b0;
      txd <= 1'b1;
    end else begin
      if (tx_cnt != 22'h00_0000)
        tx_cnt <= tx_cnt - 22'h00_0001;
      case (tx_st)
        S_IDLE: begin
          if (tx_go) begin
            tx_sh <= tx_mem[tx_rp[AW-1:0]];
            tx_st <= S_START;
            tx_cnt <= bit_len - 22'h00_0001;
            tx_idx <= 3'd0;
            tx_half <= 1'b0;
          end
        end
        S_START: begin
          if (tx_cnt == 22'h00_0000) begin
            tx_st <= S_DATA;
            tx_cnt <= bit_len - 22'h00_0001;
          end
        end
        S_DATA: begin
          if (tx_cnt == 22'h00_0000) begin
            tx_cnt <= bit_len - 22'h00_0001;
            tx_idx <= tx_idx + 3'd1;
            if (tx_idx == last_bit)
              tx_st <= par_en ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          if (tx_cnt == 22'h00_0000) begin
            tx_st <= S_STOP;
            tx_cnt <= bit_len - 22'h00_0001;
          end
        end
        S_STOP: begin
          if (tx_cnt == 22'h00_0000) begin
            if (stop2 && !tx_half) begin
              tx_half <= 1'b1;
              tx_cnt <= (last_bit == 3'd4 ? half_len : bit_len) -
                        22'h00_0001; // RQ22
            end else
              tx_st <= S_IDLE;
          end
        end
        default: tx_st <= S_IDLE;
      endcase
      if (irda)
        txd <= tx_level_low(tx_st, tx_sh[tx_idx], tx_par_bit(tx_sh)) &&
               (bit_len - tx_cnt) <= pulse_len; // RQ15
      else
        txd <= ~tx_level_low(tx_st, tx_sh[tx_idx], tx_par_bit(tx_sh));
    end
  end

  function tx_par_bit;
    input [7:0] d;
    begin
      tx_par_bit = ^(d & ~(8'hFF << ({1'b0, last_bit} + 4'd1))) ^
                   ~line_reg[4];
    end
  endfunction

  function tx_level_low;
    input [2:0] st;
    input       dbit;
    input       pbit;
    begin
      case (st)
        S_START: tx_level_low = 1'b1;
        S_DATA:  tx_level_low = ~dbit;
        S_PAR:   tx_level_low = ~pbit;
        default: tx_level_low = 1'b0;
      endcase
    end
  endfunction

  // Receiver and idle timeout.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_st <= S_IDLE;
      rx_cnt <= 22'h00_0000;
      rx_idx <= 3'd0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      tout_cnt <= 22'h00_0000;
      tout_bits <= 6'h00;
      tout_reg <= 1'b0;
    end else begin
      if (rx_cnt != 22'h00_0000)
        rx_cnt <= rx_cnt - 22'h00_0001;
      case (rx_st)
        S_IDLE: begin
          if (!rx_line && rx_allow) begin // RQ10
            rx_st <= S_START;
            rx_cnt <= half_len;
          end
        end
        S_START: begin
          if (rx_cnt == 22'h00_0000) begin
            if (rx_line)
              rx_st <= S_IDLE; // RQ23
            else begin
              rx_st <= S_DATA;
              rx_cnt <= bit_len - 22'h00_0001;
              rx_idx <= 3'd0;
              rx_sh <= 8'h00;
            end
          end
        end
        S_DATA: begin
          if (rx_cnt == 22'h00_0000) begin
            rx_sh <= {rx_line, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'd1;
            rx_cnt <= bit_len - 22'h00_0001;
            if (rx_idx == last_bit)
              rx_st <= par_en ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          if (rx_cnt == 22'h00_0000) begin
            rx_par <= rx_line;
            rx_st <= S_STOP;
            rx_cnt <= bit_len - 22'h00_0001;
          end
        end
        S_STOP: begin
          if (rx_cnt == 22'h00_0000) begin
            rx_par <= 1'b0;
            rx_st <= rx_line ? S_IDLE : S_BRK;
          end
        end
        S_BRK: begin
          if (rx_line)
            rx_st <= S_IDLE;
        end
        default: rx_st <= S_IDLE;
      endcase
      if (rx_st != S_IDLE || rx_empty || rd_data) begin
        tout_cnt <= 22'h00_0000;
        tout_bits <= 6'h00;
        tout_reg <= 1'b0;
      end else if (tout_bits == `TOUT_BITS)
        tout_reg <= 1'b1;
      else if (tout_cnt >= bit_len - 22'h00_0001) begin
        tout_cnt <= 22'h00_0000;
        tout_bits <= tout_bits + 6'h01;
      end else
        tout_cnt <= tout_cnt + 22'h00_0001;
    end
  end
endmodule
`default_nettype wire

// >>> src/uart_regs.vh
`ifndef UART_REGS_VH
`define UART_REGS_VH
// Byte offsets of the registers.
`define OFF_DATA    5'h00
`define OFF_LINE    5'h04
`define OFF_FIFO    5'h08
`define OFF_STATUS  5'h0C
`define OFF_IRQ     5'h10
`define OFF_BAUD    5'h14
`define OFF_FUNC    5'h18
`define OFF_MODEM   5'h1C
// Field positions.
`define FCR_RX_RST   1
`define FCR_TX_RST   2
`define FCR_RXTRG_HI 7
`define FCR_RXTRG_LO 4
`define FCR_RTS_HI   19
`define FCR_RTS_LO   16
`define FUN_LIN      0
`define FUN_IRDA     1
`define BAUD_X_HI    27
`define BAUD_X_LO    24
`define BAUD_X_ONE   28
`define BAUD_X_EN    29
// Reset values.
`define RST_LINE     5'h03
`define RST_BAUD     32'h0000_0000
`define RST_FIFO     8'h01
// Timing counts.
`define OVERSAMPLE   5'h10
`define BAUD_OFFSET  22'h00_0002
`define TOUT_BITS    6'h28
`define IRDA_MAX_BPS 115200
`endif

// >>> dv/uart_channel_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
module uart_channel_checker #(
  parameter CHANNEL = 0
) (
  // Clock and reset
  input wire        clk_sys,
  input wire        reset,
  // Register bus
  input wire [4:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Serial pins
  input wire        rxd,
  input wire        txd,
  input wire        cts_n,
  input wire        rts_n
);
  localparam int DEPTH = (CHANNEL == 0) ? 64 : 16;
  logic        st_q, arts, arts_q, irda_seen;
  logic [1:0]  rcnt;
  logic [31:0] baud, lowrun;
  wire         acc  = write && !waitrequest;
  wire  [31:0] div2 = {16'h0000, baud[15:0]} + 32'h0000_0002;
  wire  [31:0] xm   = {28'h000_0000, baud[27:24]} + 32'h0000_0001;
  wire  [31:0] per  = !baud[`BAUD_X_EN] ? div2 << 4 :
                      baud[`BAUD_X_ONE] ? div2 : xm * div2;
  // Mirrors the configuration that the bus has written.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q      <= 1'b0;
      arts      <= 1'b0;
      arts_q    <= 1'b0;
      irda_seen <= 1'b0;
      rcnt      <= 2'b00;
      baud      <= `RST_BAUD;
      lowrun    <= 32'h0000_0000;
    end else begin
      if ((read || write) && waitrequest)
        st_q <= read && (address == `OFF_STATUS);
      if (acc && address == `OFF_BAUD)
        baud <= writedata;
      if (acc && address == `OFF_MODEM)
        arts <= writedata[0];
      if (acc && address == `OFF_FUNC && writedata[`FUN_IRDA])
        irda_seen <= 1'b1;
      arts_q <= arts;
      if (rcnt != 2'b11)
        rcnt <= rcnt + 2'b01;
      lowrun <= txd ? 32'h0000_0000 : lowrun + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_st; !waitrequest && st_q; endsequence
  AST_WAIT_ANSWER: assert property (s_req |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("answer lasted more than one cycle");
  AST_RDATA_HOLD: assert property (
    !(read && waitrequest) |=> $stable(readdata))
    else $error("read data changed without a read");
  AST_RX_EMPTY: assert property (
    s_st |-> readdata[0] == (readdata[22:16] == 0))
    else $error("receive empty flag disagrees with count");
  AST_TX_EMPTY: assert property (
    s_st |-> readdata[2] == (readdata[30:24] == 0))
    else $error("transmit empty flag disagrees with count");
  AST_DEPTH: assert property (
    s_st |-> readdata[22:16] <= DEPTH && readdata[30:24] <= DEPTH)
    else $error("buffer count beyond depth");
  AST_TX_FULL: assert property (
    s_st |-> readdata[1] == (readdata[30:24] == DEPTH))
    else $error("transmit full flag disagrees with depth");
  AST_BAUD_RUN: assert property (
    $rose(txd) && !irda_seen |-> lowrun % per == 0)
    else $error("low run on txd is not whole bit periods");
  AST_RTS_FREE: assert property (
    (CHANNEL < 2) && rcnt == 2'b11 && !arts && !arts_q |-> !rts_n)
    else $error("request-to-send not held asserted without auto mode");
endmodule
bind uart_channel uart_channel_checker #(.CHANNEL(CHANNEL)) chk (
  .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .cts_n(cts_n),
  .rts_n(rts_n));
`default_nettype wire

// >>> dv/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Clock
  input  wire logic clk_sys,
  // Lines from the channel
  input  wire logic txd,
  input  wire logic rts_n,
  // Lines to the channel
  output var  logic rxd,
  output var  logic cts_n
);
  int          bp   = 32;
  int          nb   = 8;
  bit          obey = 1'b1;
  bit          on   = 1'b1;
  logic [11:0] rq[$];
  logic [11:0] v;
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b0;
  end
  // Sends n bits of f, lowest first, then returns the line to idle high.
  task automatic send(input logic [11:0] f, input int n);
    if (obey) while (rts_n !== 1'b0) @(posedge clk_sys);
    for (int i = 0; i < n; i++) repeat (bp) @(posedge clk_sys) rxd <= f[i];
    @(posedge clk_sys) rxd <= 1'b1;
  endtask
  // Samples nb bits at mid-bit after a start bit and queues them.
  always @(negedge txd) if (on) begin
    repeat (bp / 2) @(posedge clk_sys);
    if (txd === 1'b0) begin
      v = '0;
      for (int i = 0; i < nb; i++) begin
        repeat (bp) @(posedge clk_sys);
        v[i] = txd;
      end
      rq.push_back(v);
      repeat (bp) @(posedge clk_sys);
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  logic        clk_sys = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0000_0000, q;
  wire  [31:0] readdata;
  wire         waitrequest, txd, rts_n, rxd, cts_n;
  int          n_errors = 0, check_count = 0, cyc = 0, n, m;
  int          per [3] = '{32, 18, 5};
  logic [31:0] bd [3] = '{32'h0000_0000, 32'h2800_0000, 32'h3000_0003};
  logic [7:0]  d, b [3];
  logic [11:0] e, r;
  logic        bad, pv;
  uart_channel #(.CHANNEL(0)) dut (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .cts_n(cts_n),
    .rts_n(rts_n));
  serial_peer peer (.clk_sys(clk_sys), .txd(txd), .rts_n(rts_n),
    .rxd(rxd), .cts_n(cts_n));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    void'($urandom(45847));
    wt(16);
    reset <= 1'b0;
    bus(0, `OFF_LINE, 0); `CHK(q, {27'h000_0000, `RST_LINE})
    bus(0, `OFF_BAUD, 0); `CHK(q, `RST_BAUD)
    bus(0, `OFF_STATUS, 0); `CHK(q[2:0], 3'b101)
    bus(0, 5'h1E, 0); `CHK(q, 32'h0000_0000)
    tend("reset");
    for (int i = 0; i < 3; i++) begin
      bus(1, `OFF_BAUD, bd[i]);
      peer.bp = per[i];
      d = $urandom | 1;
      bus(1, `OFF_DATA, {24'h00_0000, d});
      while (txd !== 1'b0) @(posedge clk_sys);
      n = 0;
      while (txd === 1'b0) begin @(posedge clk_sys); n++; end
      `CHK(n, per[i])
      wt(11 * per[i]);
      r = peer.rq.pop_front(); `CHK(r[7:0], d)
    end
    bus(1, `OFF_BAUD, bd[1]);
    peer.bp = 18;
    tend("baud");
    for (int l = 0; l < 4; l++) for (int p = 0; p < 3; p++) begin
      m = l + 5;
      d = $urandom & ((1 << m) - 1);
      e = {4'h0, d};
      if (p != 0) e[m] = ^d ^ (p == 1);
      peer.nb = m + (p != 0);
      bus(1, `OFF_LINE, {27'h000_0000, p == 2, p != 0,
                         1'($urandom), 2'(l)});
      bus(1, `OFF_DATA, {24'h00_0000, d});
      wt(14 * 18);
      r = peer.rq.pop_front(); `CHK(r, e)
    end
    peer.nb = 8;
    tend("format");
    bus(1, `OFF_LINE, 32'h0000_001B);
    d = $urandom;
    peer.send({1'b1, ^d, d, 1'b0}, 11);
    wt(36);
    bus(0, `OFF_DATA, 0); `CHK(q[7:0], d)
    peer.send({1'b1, ~^d, d, 1'b0}, 11);
    wt(36);
    bus(0, `OFF_STATUS, 0); `CHK(q[4], 1'b1)
    bus(0, `OFF_IRQ, 0); `CHK(q[2], 1'b1)
    bus(1, `OFF_STATUS, 32'h0000_03F8);
    peer.send(12'h000, 11);
    wt(36);
    bus(0, `OFF_STATUS, 0); `CHK(q[6], 1'b1)
    bus(1, `OFF_FIFO, 32'h0000_0012);
    bus(1, `OFF_STATUS, 32'h0000_03F8);
    peer.bp = 4;
    peer.send(12'h000, 1);
    peer.bp = 18;
    wt(12 * 18);
    bus(0, `OFF_STATUS, 0); `CHK({q[0], q[22:16]}, 8'h80)
    bus(1, `OFF_LINE, 32'h0000_0003);
    tend("receive");
    bus(1, `OFF_MODEM, 32'h0000_0002);
    peer.cts_n <= 1'b1;
    d = $urandom;
    bus(1, `OFF_DATA, {24'h00_0000, d});
    bad = 1'b0;
    repeat (90) begin @(posedge clk_sys); bad |= txd !== 1'b1; end
    `CHK(bad, 1'b0)
    peer.cts_n <= 1'b0;
    wt(14 * 18);
    r = peer.rq.pop_front(); `CHK(r[7:0], d)
    // Clear-to-send held off so the transmit buffer can be filled.
    peer.cts_n <= 1'b1;
    wt(4);
    for (int i = 0; i < 64; i++) bus(1, `OFF_DATA, {24'h00_0000, 8'(i)});
    bus(0, `OFF_STATUS, 0); `CHK({q[1], q[30:24]}, 8'hC0)
    bus(1, `OFF_DATA, 32'h0000_00AA);
    bus(0, `OFF_STATUS, 0); `CHK({q[7], q[30:24]}, 8'hC0)
    bus(1, `OFF_FIFO, 32'h0000_0014);
    bus(0, `OFF_STATUS, 0); `CHK(q[2], 1'b1)
    peer.cts_n <= 1'b0;
    bus(1, `OFF_MODEM, 32'h0000_0000);
    tend("clear");
    bus(1, `OFF_FIFO, 32'h0002_0010);
    bus(1, `OFF_MODEM, 32'h0000_0001);
    wt(4); `CHK(rts_n, 1'b0)
    for (int i = 0; i < 3; i++) begin
      b[i] = $urandom;
      peer.obey = (i != 2);
      peer.send({3'b001, b[i], 1'b0}, 10);
      wt(20);
    end
    `CHK(rts_n, 1'b1)
    bus(0, `OFF_STATUS, 0); `CHK(q[22:16], 7'h02)
    for (int i = 0; i < 2; i++) begin
      bus(0, `OFF_DATA, 0); `CHK(q[7:0], b[i])
    end
    wt(4); `CHK(rts_n, 1'b0)
    peer.obey = 1'b1;
    bus(1, `OFF_MODEM, 32'h0000_0000);
    tend("request");
    bus(1, `OFF_LINE, 32'h0000_0000);
    bus(1, `OFF_FUNC, 32'h0000_0001);
    d = $urandom;
    bus(1, `OFF_DATA, {24'h00_0000, d});
    wt(14 * 18);
    r = peer.rq.pop_front(); `CHK(r[7:0], d)
    tend("lin");
    // A receive pulse sent during the transmission must be ignored, as infrared is half duplex.
    peer.on = 1'b0;
    peer.rxd <= 1'b0;
    bus(1, `OFF_FUNC, 32'h0000_0002);
    wt(8); `CHK(txd, 1'b0)
    bus(1, `OFF_DATA, 32'h0000_0000);
    n = 0;
    pv = txd;
    fork
      repeat (12 * 18) begin
        @(posedge clk_sys);
        if (txd === 1'b1 && pv === 1'b0) n++;
        pv = txd;
      end
      begin wt(40); peer.rxd <= 1'b1; wt(3); peer.rxd <= 1'b0; end
    join
    `CHK(n, 9)
    bus(0, `OFF_STATUS, 0); `CHK(q[0], 1'b1)
    tend("infrared");
    test_done;
  end
endmodule
`default_nettype wire
